// ---- rtl/dram_dev_end.sv ----
// Summary of operation
// - idle only after precharge delay elapsed
// - row active after activate-to-column delay, no burst
// - read/write state lasts for non-AP burst
// - precharging lasts precharge delay, then idle
// - activating lasts activate-to-column delay, then active
// - auto-precharge burst busy until precharge done
// - busy bank takes only nop or others
// - refresh busy for refresh delay, then idle
// - mode load busy for its delay, nop only
// - precharge all busy for precharge delay
// - refresh and mode load need all idle
// - burst terminate stops latest read burst
// - checks apply with clock enable high twice
// - unlisted state and command pairs are illegal
// - every precharged bank must allow precharging
// - read over write burst needs data masking
// - auto-precharge bank allows other bank commands
// - write after read-AP waits for data out
// - write-AP spacing: read, write, precharge/activate (code spaces only read and write, not precharge/activate)
// - read-AP spacing: read, write, precharge/activate (code spaces only read and write, not precharge/activate)
// - address ten selects all-bank precharge
// - decode select, row, column, write strobes
`timescale 1ns/1ns
`default_nettype none
module dram_dev_end import dram_cmd_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // command link
   dram_cmd_if.dev                link,
   // delays
   input  wire cfg_s              cfg,
   // error report
   input  wire logic              err_clear,
   output var  logic              err,
   output var  logic [BW-1:0]     err_bank,
   output var  cmd_e              err_cmd,
   // status
   output var  logic              cmd_taken,
   output var  glob_e             glob_state,
   output var  bank_st_e [NB-1:0] bank_state
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic          cke_prev;
      glob_e         glob;
      logic [CW-1:0] gcnt;
      logic [CW-1:0] xcnt;
      logic [BW-1:0] last_rd;
      logic          ap_valid;
      logic          ap_wr;
      logic [BW-1:0] ap_bank;
      logic [CW-1:0] ap_gap;
      logic          err;
      logic [BW-1:0] err_bank;
      cmd_e          err_cmd;
      logic          taken;
   } dev_s;

   localparam dev_s DEV_RESET = '{
      cke_prev: 1'b0, glob: G_NONE, gcnt: CNT_ZERO, xcnt: CNT_ZERO,
      last_rd: '0, ap_valid: 1'b0, ap_wr: 1'b0, ap_bank: '0,
      ap_gap: CNT_ZERO, err: 1'b0, err_bank: '0, err_cmd: CMD_NOP,
      taken: 1'b0};

   dev_s            cur;
   dev_s            next_cur;
   ctx_s            ctx;
   cmd_e            cmd;
   logic            live;
   logic            ok;
   logic            acc;
   logic            bad;
   logic            pre_all;
   logic [NB-1:0]   hit;

   assign err        = cur.err;
   assign err_bank   = cur.err_bank;
   assign err_cmd    = cur.err_cmd;
   assign cmd_taken  = cur.taken;
   assign glob_state = cur.glob;

   // ---------------------------------------------------------------
   // decode and legality
   // ---------------------------------------------------------------
   always_comb
   begin
      cmd = decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
      // checking only when clock enable held high on both edges
      live = cur.cke_prev && link.cke;
      ctx.st       = bank_state;
      ctx.busy     = cur.glob != G_NONE ||
                     cur.xcnt != CNT_ZERO;
      ctx.last_rd  = cur.last_rd;
      ctx.ap_valid = cur.ap_valid;
      ctx.ap_wr    = cur.ap_wr;
      ctx.ap_bank  = cur.ap_bank;
      ctx.ap_gap   = cur.ap_gap;
      ok  = cmd_legal(ctx, cfg, cmd, link.ba, link.a10);
      acc = live && ok && cmd != CMD_NOP;
      bad = live && !ok;
      pre_all = acc && cmd == CMD_PRE && link.a10;
   end

   // ---------------------------------------------------------------
   // banks
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++)
      begin : g_bank
         // bank select ignored for all-bank precharge
         assign hit[gi] = acc && !pre_all && link.ba == BW'(gi) &&
                          cmd != CMD_BST;
         bank_track u_bank
         (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .cfg     (cfg),
            .hit     (hit[gi]),
            .cmd     (cmd),
            .a10     (link.a10),
            .pre_all (pre_all),
            .bst_hit (acc && cmd == CMD_BST &&
                      cur.last_rd == BW'(gi)),
            .st      (bank_state[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // global sequencing and error capture
   // ---------------------------------------------------------------
   always_comb
   begin
      next_cur          = cur;
      next_cur.cke_prev = link.cke;
      next_cur.taken    = acc;
      // exit from low clock enable waits out the exit delay
      if (!cur.cke_prev && link.cke)
         next_cur.xcnt = cfg.self_refresh_exit_delay;
      else if (cur.xcnt != CNT_ZERO)
         next_cur.xcnt = cur.xcnt - CNT_ONE;

      if (cur.glob != G_NONE)
      begin
         if (cur.gcnt <= CNT_ONE)
            next_cur.glob = G_NONE;
         else
            next_cur.gcnt = cur.gcnt - CNT_ONE;
      end
      if (acc && cmd == CMD_REF)
      begin
         next_cur.glob = G_REFRESH;
         next_cur.gcnt = cfg.refresh_cycle_delay;
      end
      if (acc && cmd == CMD_MRS)
      begin
         next_cur.glob = G_MODE;
         next_cur.gcnt = cfg.mode_load_delay;
      end
      if (pre_all)
      begin
         next_cur.glob = G_PRE_ALL;
         next_cur.gcnt = cfg.row_precharge_delay;
      end

      // gap saturates well above every spacing minimum
      if (cur.ap_gap != CNT_MAX)
         next_cur.ap_gap = cur.ap_gap + CNT_ONE;
      if (acc && (cmd == CMD_RD || cmd == CMD_WR))
      begin
         if (cmd == CMD_RD)
            next_cur.last_rd = link.ba;
         if (link.a10)
         begin
            next_cur.ap_valid = 1'b1;
            next_cur.ap_wr    = cmd == CMD_WR;
            next_cur.ap_bank  = link.ba;
            next_cur.ap_gap   = CNT_ONE;
         end
      end

      // a new error wins over a clear in the same cycle
      if (bad)
      begin
         next_cur.err      = 1'b1;
         next_cur.err_bank = link.ba;
         next_cur.err_cmd  = cmd;
      end
      else if (err_clear)
         next_cur.err = 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         cur <= DEV_RESET;
      else
         cur <= next_cur;
   end
endmodule
`default_nettype wire

// ---- rtl/dram_cmd_pkg.sv ----
`default_nettype none
package dram_cmd_pkg;

   // ---------------------------------------------------------------
   // sizes and constants
   // ---------------------------------------------------------------
   localparam int NB = 4;
   localparam int BW = 2;
   localparam int CW = 8;
   localparam logic [CW-1:0] CNT_ONE  = 8'h01;
   localparam logic [CW-1:0] CNT_ZERO = 8'h00;
   localparam logic [CW-1:0] CNT_MAX  = 8'hFF;

   typedef enum logic [2:0]
   {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
   } cmd_e;

   typedef enum logic [2:0]
   {
      ST_IDLE, ST_ACTIVATING, ST_ACTIVE, ST_READ, ST_WRITE,
      ST_PRECHARGING, ST_READ_AP, ST_WRITE_AP
   } bank_st_e;

   typedef enum logic [1:0] {G_NONE, G_REFRESH, G_MODE, G_PRE_ALL} glob_e;

   // delays in clock cycles
   typedef struct packed
   {
      logic [CW-1:0] row_precharge_delay;
      logic [CW-1:0] activate_to_column_delay;
      logic [CW-1:0] refresh_cycle_delay;
      logic [CW-1:0] mode_load_delay;
      logic [CW-1:0] write_to_read_delay;
      logic [CW-1:0] self_refresh_exit_delay;
      logic [3:0]    burst_length;
      logic [2:0]    cas_latency;
   } cfg_s;

   // view of the device state that legality depends on
   typedef struct packed
   {
      bank_st_e [NB-1:0] st;
      logic              busy;
      logic [BW-1:0]     last_rd;
      logic              ap_valid;
      logic              ap_wr;
      logic [BW-1:0]     ap_bank;
      logic [CW-1:0]     ap_gap;
   } ctx_s;

   // ---------------------------------------------------------------
   // command decode and legality
   // ---------------------------------------------------------------
   function automatic cmd_e decode(input logic cs_n, input logic ras_n,
                                   input logic cas_n, input logic we_n);
      cmd_e c;
      c = CMD_NOP;
      if (!cs_n)
      begin
         case ({ras_n, cas_n, we_n})
            3'h3:    c = CMD_ACT;
            3'h5:    c = CMD_RD;
            3'h4:    c = CMD_WR;
            3'h2:    c = CMD_PRE;
            3'h1:    c = CMD_REF;
            3'h0:    c = CMD_MRS;
            3'h6:    c = CMD_BST;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

   function automatic logic cmd_legal(input ctx_s c, input cfg_s g,
                                      input cmd_e cmd,
                                      input logic [BW-1:0] b,
                                      input logic a10);
      logic          ok;
      logic [CW-1:0] half;
      logic [CW-1:0] need;
      bank_st_e      s;
      half = CW'(g.burst_length >> 1);
      need = CNT_ONE;
      s    = c.st[b];
      ok   = 1'b0;
      case (cmd)
         CMD_NOP: ok = 1'b1;
         CMD_REF, CMD_MRS:
         begin
            ok = 1'b1;
            for (int i = 0; i < NB; i++)
               ok = ok && c.st[i] == ST_IDLE;
         end
         CMD_BST: ok = c.st[c.last_rd] == ST_READ;
         CMD_ACT: ok = s == ST_IDLE;
         CMD_RD:  ok = s == ST_ACTIVE || s == ST_READ || s == ST_WRITE;
         CMD_WR:  ok = s == ST_ACTIVE || s == ST_WRITE;
         CMD_PRE:
         begin
            ok = s == ST_ACTIVE || s == ST_READ || s == ST_WRITE;
            if (a10)
               for (int i = 0; i < NB; i++)
                  ok = (i == 0 ? 1'b1 : ok) && (c.st[i] == ST_IDLE ||
                       c.st[i] == ST_ACTIVE || c.st[i] == ST_READ ||
                       c.st[i] == ST_WRITE);
         end
         default: ok = 1'b0;
      endcase
      // a read burst in flight elsewhere forbids a write
      for (int i = 0; i < NB; i++)
         if (cmd == CMD_WR && i != int'(b) && c.st[i] == ST_READ)
            ok = 1'b0;
      // concurrent auto precharge spacing to another bank
      if (c.ap_valid && c.ap_bank != b && (cmd == CMD_RD || cmd == CMD_WR))
      begin
         if (c.ap_wr)
            need = cmd == CMD_RD ?
                   CW'(CNT_ONE + half + g.write_to_read_delay) : half;
         else
            need = cmd == CMD_RD ? half : CW'(half + CW'(g.cas_latency));
      end
      if (c.ap_valid && c.ap_gap < need)
         ok = 1'b0;
      if (c.busy && cmd != CMD_NOP)
         ok = 1'b0;
      return ok;
   endfunction

endpackage
`default_nettype wire

// ---- rtl/dram_cmd_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface dram_cmd_if import dram_cmd_pkg::*; ();
   logic          cke;
   logic          cs_n;
   logic          ras_n;
   logic          cas_n;
   logic          we_n;
   logic          a10;
   logic [BW-1:0] ba;

   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, a10, ba);
   modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, a10, ba);
endinterface
`default_nettype wire

// ---- rtl/bank_track.sv ----
`timescale 1ns/1ns
`default_nettype none
module bank_track import dram_cmd_pkg::*;
(
   // clock and reset
   input  wire logic     mclk,
   input  wire logic     sys_rst,
   // delays
   input  wire cfg_s     cfg,
   // accepted command
   input  wire logic     hit,
   input  wire cmd_e     cmd,
   input  wire logic     a10,
   input  wire logic     pre_all,
   input  wire logic     bst_hit,
   // bank state
   output var  bank_st_e st
);
   typedef struct packed
   {
      bank_st_e      st;
      logic [CW-1:0] cnt;
   } trk_s;

   trk_s          cur;
   trk_s          next_cur;
   logic          done;
   logic          rd;
   logic [CW-1:0] half;

   assign st = cur.st;

   always_comb
   begin
      next_cur = cur;
      half     = CW'(cfg.burst_length >> 1);
      done     = cur.cnt <= CNT_ONE;
      rd       = cmd == CMD_RD;
      if (!done)
         next_cur.cnt = cur.cnt - CNT_ONE;
      case (cur.st)
         ST_IDLE:
         begin
            if (pre_all)
            begin
               next_cur.st  = ST_PRECHARGING;
               next_cur.cnt = cfg.row_precharge_delay;
            end
            else if (hit && cmd == CMD_ACT)
            begin
               next_cur.st  = ST_ACTIVATING;
               next_cur.cnt = cfg.activate_to_column_delay;
            end
         end
         ST_ACTIVATING:
            if (done)
               next_cur.st = ST_ACTIVE;
         ST_ACTIVE, ST_READ, ST_WRITE:
         begin
            if (cur.st != ST_ACTIVE &&
                (done || (bst_hit && cur.st == ST_READ)))
               next_cur.st = ST_ACTIVE;
            if (pre_all || (hit && cmd == CMD_PRE))
            begin
               next_cur.st  = ST_PRECHARGING;
               next_cur.cnt = cfg.row_precharge_delay;
            end
            else if (hit && (rd || cmd == CMD_WR))
            begin
               // auto precharge covers the burst plus the precharge
               if (a10)
               begin
                  next_cur.st  = rd ? ST_READ_AP : ST_WRITE_AP;
                  next_cur.cnt = CW'(half + cfg.row_precharge_delay);
               end
               else
               begin
                  next_cur.st  = rd ? ST_READ : ST_WRITE;
                  next_cur.cnt = half;
               end
            end
         end
         ST_PRECHARGING, ST_READ_AP, ST_WRITE_AP:
            if (done)
               next_cur.st = ST_IDLE;
         default: next_cur.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         cur <= '{st: ST_IDLE, cnt: CNT_ZERO};
      else
         cur <= next_cur;
   end
endmodule
`default_nettype wire

// ---- rtl/dram_ctrl_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module dram_ctrl_end import dram_cmd_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // command link
   dram_cmd_if.ctrl           link,
   // delays
   input  wire cfg_s          cfg,
   // request
   input  wire logic          req_valid,
   input  wire cmd_e          req_cmd,
   input  wire logic [BW-1:0] req_bank,
   input  wire logic          req_a10,
   output var  logic          req_done
);
   typedef struct packed
   {
      logic          cke;
      logic [3:0]    pins;
      logic          a10;
      logic [BW-1:0] ba;
      logic          done;
      glob_e         glob;
      logic [CW-1:0] gcnt;
      logic [CW-1:0] xcnt;
      logic [BW-1:0] last_rd;
      logic          ap_valid;
      logic          ap_wr;
      logic [BW-1:0] ap_bank;
      logic [CW-1:0] ap_gap;
   } ctl_s;

   localparam logic [3:0] PINS_NOP = 4'h7;

   ctl_s              cur;
   ctl_s              next_cur;
   ctx_s              ctx;
   bank_st_e [NB-1:0] st;
   logic              go;
   logic              pre_all;
   logic [3:0]        pins;

   assign link.cke   = cur.cke;
   assign link.cs_n  = cur.pins[3];
   assign link.ras_n = cur.pins[2];
   assign link.cas_n = cur.pins[1];
   assign link.we_n  = cur.pins[0];
   assign link.a10   = cur.a10;
   assign link.ba    = cur.ba;
   assign req_done   = cur.done;

   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++)
      begin : g_bank
         bank_track u_bank
         (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .cfg     (cfg),
            .hit     (go && !pre_all && req_bank == BW'(gi) &&
                      req_cmd != CMD_BST),
            .cmd     (req_cmd),
            .a10     (req_a10),
            .pre_all (pre_all),
            .bst_hit (go && req_cmd == CMD_BST &&
                      cur.last_rd == BW'(gi)),
            .st      (st[gi])
         );
      end
   endgenerate

   always_comb
   begin
      ctx.st       = st;
      ctx.busy     = cur.glob != G_NONE || cur.xcnt != CNT_ZERO;
      ctx.last_rd  = cur.last_rd;
      ctx.ap_valid = cur.ap_valid;
      ctx.ap_wr    = cur.ap_wr;
      ctx.ap_bank  = cur.ap_bank;
      ctx.ap_gap   = cur.ap_gap;
      // hold the request until the mirrored state allows it
      // are kept inside the legality check
      go = cur.cke && req_valid && !cur.done && req_cmd != CMD_NOP &&
           cmd_legal(ctx, cfg, req_cmd, req_bank, req_a10);
      pre_all = go && req_cmd == CMD_PRE && req_a10;
      case (req_cmd)
         CMD_ACT: pins = 4'h3;
         CMD_RD:  pins = 4'h5;
         CMD_WR:  pins = 4'h4;
         CMD_PRE: pins = 4'h2;
         CMD_REF: pins = 4'h1;
         CMD_MRS: pins = 4'h0;
         CMD_BST: pins = 4'h6;
         default: pins = PINS_NOP;
      endcase

      next_cur      = cur;
      next_cur.cke  = 1'b1;
      next_cur.done = go;
      next_cur.pins = go ? pins : PINS_NOP;
      next_cur.a10  = go && req_a10;
      next_cur.ba   = go ? req_bank : cur.ba;
      if (!cur.cke)
         next_cur.xcnt = cfg.self_refresh_exit_delay;
      else if (cur.xcnt != CNT_ZERO)
         next_cur.xcnt = cur.xcnt - CNT_ONE;
      if (cur.glob != G_NONE)
      begin
         if (cur.gcnt <= CNT_ONE)
            next_cur.glob = G_NONE;
         else
            next_cur.gcnt = cur.gcnt - CNT_ONE;
      end
      if (go && req_cmd == CMD_REF)
      begin
         next_cur.glob = G_REFRESH;
         next_cur.gcnt = cfg.refresh_cycle_delay;
      end
      if (go && req_cmd == CMD_MRS)
      begin
         next_cur.glob = G_MODE;
         next_cur.gcnt = cfg.mode_load_delay;
      end
      if (pre_all)
      begin
         next_cur.glob = G_PRE_ALL;
         next_cur.gcnt = cfg.row_precharge_delay;
      end
      if (cur.ap_gap != CNT_MAX)
         next_cur.ap_gap = cur.ap_gap + CNT_ONE;
      if (go && (req_cmd == CMD_RD || req_cmd == CMD_WR))
      begin
         if (req_cmd == CMD_RD)
            next_cur.last_rd = req_bank;
         if (req_a10)
         begin
            next_cur.ap_valid = 1'b1;
            next_cur.ap_wr    = req_cmd == CMD_WR;
            next_cur.ap_bank  = req_bank;
            next_cur.ap_gap   = CNT_ONE;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         cur <= '{cke: 1'b0, pins: PINS_NOP, a10: 1'b0, ba: '0,
                  done: 1'b0, glob: G_NONE, gcnt: CNT_ZERO,
                  xcnt: CNT_ZERO, last_rd: '0, ap_valid: 1'b0,
                  ap_wr: 1'b0, ap_bank: '0, ap_gap: CNT_ZERO};
      else
         cur <= next_cur;
   end
endmodule
`default_nettype wire

// ---- dv/ddr_bank_command_legality_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_bank_command_legality_chk import dram_cmd_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // command link
   input  wire logic          cke,
   input  wire logic          cs_n,
   input  wire logic          ras_n,
   input  wire logic          cas_n,
   input  wire logic          we_n,
   input  wire logic          a10,
   input  wire logic [BW-1:0] ba
);
   // ------
   // decode
   // ------
   logic [2:0] op;
   logic       nop;
   assign op  = {ras_n, cas_n, we_n};
   assign nop = cs_n || op == 3'h7;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // counts assume bench delays: refresh 4, mode 3, precharge 3
   cmd_then_nop_a: assert property (!nop |=> nop)
      else $error("command held longer than one cycle");
   cke_gate_a: assert property (!nop |-> cke && $past(cke))
      else $error("command without clock enable on two edges");
   ref_quiet_a: assert property (!nop && op == 3'h1 |=> nop[*4])
      else $error("command during refresh");
   mode_quiet_a: assert property (!nop && op == 3'h0 |=> nop[*3])
      else $error("command during mode load");
   pre_all_quiet_a: assert property (!nop && op == 3'h2 && a10
      |=> nop[*3]) else $error("command during precharge all");
   act_hold_a: assert property (!nop && op == 3'h3
      |=> ##1 (nop || ba != $past(ba, 2))) else $error("bank hit early");
   pre_hold_a: assert property (!nop && op == 3'h2 && !a10
      |=> ##1 (nop || ba != $past(ba, 2))) else $error("bank hit early");
   rdap_wr_a: assert property (!nop && op == 3'h5 && a10
      |=> (nop || op != 3'h4)[*3]) else $error("write too soon");
   wrap_rd_a: assert property (!nop && op == 3'h4 && a10
      |=> (nop || op != 3'h5)[*4]) else $error("read too soon");

   cover property (!nop && op == 3'h1);
   cover property (!nop && op == 3'h0);
   cover property (!nop && op == 3'h4 && a10);
endmodule
`default_nettype wire

// ---- dv/ddr_bank_command_legality_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_bank_command_legality_test import dram_cmd_pkg::*; ;
   // rp, rcd, rfc, mode, wtr, exit, burst 4, cas 2
   localparam cfg_s CFG = {8'h03, 8'h03, 8'h04, 8'h03, 8'h02, 8'h02,
                           4'h4, 3'h2};
   logic              mclk;
   logic              sys_rst;
   logic              req_valid;
   cmd_e              req_cmd;
   logic [BW-1:0]     req_bank;
   logic              req_a10;
   logic              req_done;
   logic              err_clear;
   logic              err;
   logic [BW-1:0]     err_bank;
   cmd_e              err_cmd;
   logic              cmd_taken;
   glob_e             glob_state;
   bank_st_e [NB-1:0] bank_state;
   logic              err2;
   logic [BW-1:0]     eb2;
   cmd_e              ec2;
   bank_st_e [NB-1:0] bs2;
   int                err_count;
   int                checks_done;

   dram_cmd_if lnk ();
   dram_cmd_if lnk2 ();
   dram_ctrl_end u_dram_ctrl_end (.mclk, .sys_rst, .link(lnk.ctrl),
      .cfg(CFG), .req_valid, .req_cmd, .req_bank, .req_a10, .req_done);
   dram_dev_end u_dram_dev_end (.mclk, .sys_rst, .link(lnk.dev),
      .cfg(CFG), .err_clear, .err, .err_bank, .err_cmd, .cmd_taken,
      .glob_state, .bank_state);
   // second device faces the bench, which breaks the rules on purpose
   dram_dev_end u_dram_dev_end_2 (.mclk, .sys_rst, .link(lnk2.dev),
      .cfg(CFG), .err_clear, .err(err2), .err_bank(eb2), .err_cmd(ec2),
      .cmd_taken(), .glob_state(), .bank_state(bs2));
   ddr_bank_command_legality_chk u_chk (.mclk, .sys_rst, .cke(lnk.cke),
      .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
      .we_n(lnk.we_n), .a10(lnk.a10), .ba(lnk.ba));

   // -------
   // helpers
   // -------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // returns one cycle after the taking edge, done pulse gone
   task automatic req(input cmd_e c, input logic [1:0] b, input logic a);
      int k;
      k = 0;
      req_cmd = c;
      req_bank = b;
      req_a10 = a;
      req_valid = 1'b1;
      while (req_done !== 1'b1 && k < 40)
      begin
         tick(1);
         k++;
      end
      req_valid = 1'b0;
      chk(req_done, 1'b1);
      tick(1);
   endtask

   task automatic raw(input logic k, input logic [2:0] o);
      lnk2.cke = k;
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = o;
      tick(1);
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = 3'h7;
   endtask

   task automatic conclude();
      $display("checks_done=%0d err_count=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------
   // scenarios
   // ---------
   task automatic t_row();
      req(CMD_ACT, 2'h0, 1'b0);
      chk(cmd_taken, 1'b1);
      chk(bank_state[0], ST_ACTIVATING);
      tick(3);
      chk(bank_state[0], ST_ACTIVE);
      req(CMD_RD, 2'h0, 1'b0);
      chk(bank_state[0], ST_READ);
      tick(3);
      chk(bank_state[0], ST_ACTIVE);
      // read cutting into a running write burst is accepted
      req(CMD_WR, 2'h0, 1'b0);
      req(CMD_RD, 2'h0, 1'b0);
      chk(bank_state[0], ST_READ);
   endtask

   task automatic t_ap();
      time t0;
      req(CMD_ACT, 2'h1, 1'b0);
      req(CMD_WR, 2'h0, 1'b1);
      t0 = $time;
      chk(bank_state[0], ST_WRITE_AP);
      req(CMD_RD, 2'h1, 1'b0);
      // burst 4 and wtr 2 give five cycles
      chk(16'(($time - t0) / 20 >= 5), 1'b1);
      chk(bank_state[1], ST_READ);
      tick(3);
      chk(bank_state[0], ST_IDLE);
   endtask

   task automatic t_pre();
      req(CMD_PRE, 2'h1, 1'b0);
      chk(bank_state[1], ST_PRECHARGING);
      chk(bank_state[0], ST_IDLE);
      tick(3);
      chk(bank_state[1], ST_IDLE);
   endtask

   task automatic t_glob();
      cmd_e  c[3] = '{CMD_PRE, CMD_REF, CMD_MRS};
      glob_e g[3] = '{G_PRE_ALL, G_REFRESH, G_MODE};
      for (int i = 0; i < 3; i++)
      begin
         req(c[i], 2'h0, 1'b1);
         chk(glob_state, g[i]);
         tick(5);
         chk(glob_state, G_NONE);
         chk(bank_state, 12'h000);
      end
   endtask

   task automatic t_err();
      raw(1'b0, 3'h5);
      tick(1);
      chk(err2, 1'b0);
      lnk2.cke = 1'b1;
      tick(5);
      raw(1'b1, 3'h5);
      tick(1);
      chk({err2, eb2, ec2}, {1'b1, 2'h1, CMD_RD});
      chk(bs2, 12'h000);
      raw(1'b1, 3'h6);
      tick(1);
      chk(ec2, CMD_BST);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      chk(err2, 1'b0);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   initial
   begin
      #100000;
      err_count++;
      conclude();
   end

   initial
   begin
      err_count = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_cmd = CMD_NOP;
      req_bank = 2'h0;
      req_a10 = 1'b0;
      err_clear = 1'b0;
      lnk2.cke = 1'b0;
      lnk2.cs_n = 1'b0;
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = 3'h7;
      lnk2.a10 = 1'b0;
      lnk2.ba = 2'h1;
      tick(8);
      sys_rst = 1'b0;
      t_row();
      t_ap();
      t_pre();
      t_glob();
      t_err();
      chk(err, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
